// ==== verilog/uep_params.svh ====
// register offsets, field positions, reset values for the ep0 setup control block
`ifndef UEP_PARAMS_SVH
`define UEP_PARAMS_SVH
`define UEP_OFS_SETUP7 8'he7
`define UEP_OFS_DEVADDR 8'he8
`define UEP_OFS_SETUPCTL 8'hea
`define UEP_OFS_FRMHI 8'hee
`define UEP_OFS_FRMLO 8'hef
`define UEP_OFS_EP0LIM 8'hf0
`define UEP_OFS_EP0IN 8'hf2
`define UEP_OFS_EP0OUT 8'hf3
`define UEP_OFS_INTSTAT 8'hf8
`define UEP_OFS_INTMASK 8'hf9
`define UEP_OFS_AUTOCFG 8'hfa
`define UEP_BIT_ARM 7
`define UEP_BIT_LOCK 0
`define UEP_BIT_FINV 7
`define UEP_BIT_TOGGLE 4
`define UEP_BIT_TSET 3
`define UEP_BIT_TCLR 2
`define UEP_BIT_NAK 1
`define UEP_BIT_STALL 0
`define UEP_INT_ADDR 0
`define UEP_INT_SETUP 1
`define UEP_INT_SOF 2
`define UEP_RST_FRMHI 8'h80
`define UEP_RST_EP0LIM 8'h40
`define UEP_EP0LIM_MASK 8'h78
`define UEP_REQ_SET_ADDRESS 8'h05
`define UEP_TYPE_STD_DEV_OUT 8'h00
`endif

// ==== verilog/uep_pkg.sv ====
// types for the ep0 setup control block
package uep_pkg;
  typedef enum logic [1:0]
  {
    UEP_ADDR_IDLE = 2'b00,
    UEP_ADDR_WAIT_STATUS = 2'b01
  } uep_addr_state_t;
endpackage

// ==== verilog/uep_ep0_setup_ctrl.sv ====
// usb device ep0 setup capture, auto address, setup lock, frame number and ep0 packet limit
`timescale 1ns/100ps
`include "uep_params.svh"
module uep_ep0_setup_ctrl
  import uep_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // from the serial engine (same clock)
  input wire logic setup_done_in,
  input wire logic [63:0] setup_data_in,
  input wire logic status_done_in,
  input wire logic sof_valid_in,
  input wire logic sof_error_in,
  input wire logic [10:0] sof_frame_index_in,
  input wire logic in_token_in,
  // to the serial engine
  output logic [6:0] device_address_out,
  output logic ep0_in_nak_out,
  output logic ep0_in_stall_out,
  output logic ep0_out_nak_out,
  output logic ep0_out_stall_out,
  output logic ep0_in_toggle_out,
  output logic ep0_out_toggle_out,
  output logic [3:0] ep0_packet_limit_out,
  output logic ep0_in_force_nak_resp_out,
  // interrupt
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0] setup7_ff;
  logic [6:0] req_addr_ff;
  logic [6:0] addr_ff;
  logic arm_ff;
  logic lock_ff;
  logic auto_en_ff;
  logic frm_inv_ff;
  logic [10:0] frm_ff;
  logic [7:0] frm_lo_snap_ff;
  logic [3:0] lim_ff;
  logic [1:0] in_ctl_ff;
  logic [1:0] out_ctl_ff;
  logic in_tog_ff;
  logic out_tog_ff;
  logic [2:0] int_stat_ff;
  logic [2:0] int_mask_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic in_nak_resp_ff;
  uep_addr_state_t addr_st_ff;
  uep_addr_state_t nxt_addr_st;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_addr = reg_wr_in && hit(reg_addr_in, `UEP_OFS_DEVADDR);
  wire wr_setupctl = reg_wr_in && hit(reg_addr_in, `UEP_OFS_SETUPCTL);
  wire wr_lim = reg_wr_in && hit(reg_addr_in, `UEP_OFS_EP0LIM);
  wire wr_in = reg_wr_in && hit(reg_addr_in, `UEP_OFS_EP0IN);
  wire wr_out = reg_wr_in && hit(reg_addr_in, `UEP_OFS_EP0OUT);
  wire wr_stat = reg_wr_in && hit(reg_addr_in, `UEP_OFS_INTSTAT);
  wire wr_mask = reg_wr_in && hit(reg_addr_in, `UEP_OFS_INTMASK);
  wire wr_auto = reg_wr_in && hit(reg_addr_in, `UEP_OFS_AUTOCFG);
  wire rd_frmhi = reg_rd_in && hit(reg_addr_in, `UEP_OFS_FRMHI);

  // a standard host-to-device SET_ADDRESS seen in the captured setup bytes
  wire is_set_addr = (setup_data_in[15:8] == `UEP_REQ_SET_ADDRESS) &&
                     (setup_data_in[7:0] == `UEP_TYPE_STD_DEV_OUT);
  wire set_addr_rx = setup_done_in && is_set_addr;
  wire wait_status = (addr_st_ff == UEP_ADDR_WAIT_STATUS);
  // load happens when auto assign runs it, or when software armed the latch instead
  wire addr_load = wait_status && status_done_in && (auto_en_ff || arm_ff);
  // ----------------------------------------------------------------------
  // address state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_addr_st = addr_st_ff;
    unique case (addr_st_ff)
      UEP_ADDR_IDLE:
        if (set_addr_rx)
          nxt_addr_st = UEP_ADDR_WAIT_STATUS;
      UEP_ADDR_WAIT_STATUS:
        if (status_done_in)
          nxt_addr_st = UEP_ADDR_IDLE;
        else if (setup_done_in && !is_set_addr)
          nxt_addr_st = UEP_ADDR_IDLE;
      default:
        nxt_addr_st = UEP_ADDR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      addr_st_ff <= UEP_ADDR_IDLE;
    else
      addr_st_ff <= nxt_addr_st;
  end

  // ----------------------------------------------------------------------
  // setup capture and address register
  // ----------------------------------------------------------------------
  // only the top setup byte is kept here; the other seven live outside this block
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      setup7_ff <= 8'h00;
    else if (setup_done_in)
      setup7_ff <= setup_data_in[63:56];
  end

  // wValue low byte carries the requested address
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      req_addr_ff <= 7'h00;
    else if (set_addr_rx)
      req_addr_ff <= setup_data_in[22:16];
  end

  // the hardware load wins over a software write in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      addr_ff <= 7'h00;
    else if (addr_load)
      addr_ff <= req_addr_ff;
    else if (wr_addr)
      addr_ff <= reg_wdata_in[6:0];
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      arm_ff <= 1'b0;
    else if (wr_addr)
      arm_ff <= reg_wdata_in[`UEP_BIT_ARM];
  end

  // auto assign is on out of reset so a bare device still answers enumeration
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      auto_en_ff <= 1'b1;
    else if (wr_auto)
      auto_en_ff <= reg_wdata_in[0];
  end

  // ----------------------------------------------------------------------
  // setup lock and ep0 override bits
  // ----------------------------------------------------------------------
  wire in_wr_ok = wr_in && !lock_ff;
  wire out_wr_ok = wr_out && !lock_ff;

  // a new setup wins over a software clear in the same cycle
  // software releases the lock by writing zero to bit 0
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      lock_ff <= 1'b0;
    else if (setup_done_in)
      lock_ff <= 1'b1;
    else if (wr_setupctl)
      lock_ff <= reg_wdata_in[`UEP_BIT_LOCK];
  end

  // writes reach nak and stall only while the lock is clear, from reset or once software releases it
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      in_ctl_ff <= 2'b00;
    else if (setup_done_in)
      in_ctl_ff <= 2'b10;
    else if (in_wr_ok)
      in_ctl_ff <= reg_wdata_in[`UEP_BIT_NAK:`UEP_BIT_STALL];
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      out_ctl_ff <= 2'b00;
    else if (setup_done_in)
      out_ctl_ff <= 2'b10;
    else if (out_wr_ok)
      out_ctl_ff <= reg_wdata_in[`UEP_BIT_NAK:`UEP_BIT_STALL];
  end

  // toggle set and clear still act while locked; clear beats set
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      in_tog_ff <= 1'b0;
    else if (setup_done_in)
      in_tog_ff <= 1'b1;
    else if (wr_in && reg_wdata_in[`UEP_BIT_TCLR])
      in_tog_ff <= 1'b0;
    else if (wr_in && reg_wdata_in[`UEP_BIT_TSET])
      in_tog_ff <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      out_tog_ff <= 1'b0;
    else if (setup_done_in)
      out_tog_ff <= 1'b1;
    else if (wr_out && reg_wdata_in[`UEP_BIT_TCLR])
      out_tog_ff <= 1'b0;
    else if (wr_out && reg_wdata_in[`UEP_BIT_TSET])
      out_tog_ff <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // nak response for ep0 in, stall having priority
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      in_nak_resp_ff <= 1'b0;
    else
      in_nak_resp_ff <= in_token_in && in_ctl_ff[1] && !in_ctl_ff[0];
  end

  // ----------------------------------------------------------------------
  // frame number
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      frm_inv_ff <= 1'b1;
      frm_ff <= 11'h000;
      frm_lo_snap_ff <= 8'h00;
    end
    else
    begin
      if (sof_valid_in)
      begin
        frm_inv_ff <= sof_error_in;
        if (!sof_error_in)
          frm_ff <= sof_frame_index_in;
      end
      if (rd_frmhi)
        frm_lo_snap_ff <= frm_ff[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // packet limit, mask and interrupt status
  // ----------------------------------------------------------------------
  wire [2:0] ev = {sof_valid_in && sof_error_in, setup_done_in, addr_load};
  // reset value kept in register layout; only bits 6:3 are stored
  localparam logic [7:0] lim_rst = `UEP_RST_EP0LIM;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      lim_ff <= lim_rst[6:3];
    else if (wr_lim)
      lim_ff <= reg_wdata_in[6:3];
  end

  // mask bits line up with the status bits
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      int_mask_ff <= 3'h0;
    else if (wr_mask)
      int_mask_ff <= reg_wdata_in[2:0];
  end

  // set wins over write-one-to-clear, so an event in the clearing cycle is not lost
  wire [2:0] stat_clr = wr_stat ? reg_wdata_in[2:0] : 3'h0;
  wire [2:0] nxt_int_stat = (int_stat_ff & ~stat_clr) | ev;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      int_stat_ff <= 3'h0;
    else
      int_stat_ff <= nxt_int_stat;
  end

  // registered so irq_out comes straight from a flip-flop
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(int_stat_ff & int_mask_ff);
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // reads of unmapped addresses return zero
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr_in)
      `UEP_OFS_SETUP7: rd_mux = setup7_ff;
      `UEP_OFS_DEVADDR: rd_mux = {arm_ff, addr_ff};
      `UEP_OFS_SETUPCTL: rd_mux = {7'h00, lock_ff};
      `UEP_OFS_FRMHI: rd_mux = {frm_inv_ff, 4'h0, frm_ff[10:8]};
      `UEP_OFS_FRMLO: rd_mux = frm_lo_snap_ff;
      `UEP_OFS_EP0LIM: rd_mux = {1'b0, lim_ff, 3'h0};
      `UEP_OFS_EP0IN: rd_mux = {3'h0, in_tog_ff, 2'h0, in_ctl_ff};
      `UEP_OFS_EP0OUT: rd_mux = {3'h0, out_tog_ff, 2'h0, out_ctl_ff};
      `UEP_OFS_INTSTAT: rd_mux = {5'h00, int_stat_ff};
      `UEP_OFS_INTMASK: rd_mux = {5'h00, int_mask_ff};
      `UEP_OFS_AUTOCFG: rd_mux = {7'h00, auto_en_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_ff <= 8'h00;
    else if (reg_rd_in)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_out = rdata_ff;
  assign device_address_out = addr_ff;
  assign ep0_in_nak_out = in_ctl_ff[1];
  assign ep0_in_stall_out = in_ctl_ff[0];
  assign ep0_out_nak_out = out_ctl_ff[1];
  assign ep0_out_stall_out = out_ctl_ff[0];
  assign ep0_in_toggle_out = in_tog_ff;
  assign ep0_out_toggle_out = out_tog_ff;
  assign ep0_packet_limit_out = lim_ff;
  assign ep0_in_force_nak_resp_out = in_nak_resp_ff;
  assign irq_out = irq_ff;

endmodule // uep_ep0_setup_ctrl

// ==== sim/uep_ep0_props.sv ====
// assertions on the ports of the ep0 setup control block
`timescale 1ns/100ps
module uep_ep0_props
(
  // watched ports
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic setup_done_in,
  input wire logic status_done_in,
  input wire logic in_token_in,
  input wire logic [6:0] device_address_out,
  input wire logic ep0_in_nak_out,
  input wire logic ep0_in_stall_out,
  input wire logic ep0_out_nak_out,
  input wire logic ep0_out_stall_out,
  input wire logic ep0_in_toggle_out,
  input wire logic ep0_out_toggle_out,
  input wire logic [3:0] ep0_packet_limit_out,
  input wire logic ep0_in_force_nak_resp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_setup_nak_set: assert property (setup_done_in |=> ep0_in_nak_out && ep0_out_nak_out)
    else $error("nak override not set by setup");
  a_setup_stall_clr: assert property (setup_done_in |=> !ep0_in_stall_out && !ep0_out_stall_out)
    else $error("stall override not cleared by setup");
  a_setup_toggle_set: assert property (setup_done_in |=> ep0_in_toggle_out && ep0_out_toggle_out)
    else $error("toggle not set by setup");
  // no lock release fits between the setup and the control write
  a_lock_blocks_write: assert property (setup_done_in ##1 !(reg_wr_in && reg_addr_in == 8'hea) ##1
    (reg_wr_in && reg_addr_in == 8'hf2) |=> ep0_in_nak_out && !ep0_in_stall_out)
    else $error("locked nak or stall changed by write");
  a_nak_answer: assert property (in_token_in && ep0_in_nak_out && !ep0_in_stall_out |=> ep0_in_force_nak_resp_out)
    else $error("in token not answered with nak");
  a_read_data_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_addr_change_cause: assert property ($changed(device_address_out) |-> $past(status_done_in) ||
    ($past(reg_wr_in) && $past(reg_addr_in) == 8'he8))
    else $error("address changed without cause");
  a_limit_change_cause: assert property ($changed(ep0_packet_limit_out) |->
    $past(reg_wr_in) && $past(reg_addr_in) == 8'hf0)
    else $error("packet limit changed without write");
  c_setup: cover property (setup_done_in);
  c_status: cover property (status_done_in);
  c_nak_token: cover property (in_token_in && ep0_in_nak_out);
endmodule // uep_ep0_props

bind uep_ep0_setup_ctrl uep_ep0_props u_uep_ep0_props (.*);

// ==== sim/uep_host_model.sv ====
// host side model: setup, status, in token and frame start events
`timescale 1ns/100ps
module uep_host_model
(
  // clock
  input wire logic clk_in,
  // events towards the device
  output logic setup_done_out = 1'b0,
  output logic [63:0] setup_data_out = 64'h0,
  output logic status_done_out = 1'b0,
  output logic sof_valid_out = 1'b0,
  output logic sof_error_out = 1'b0,
  output logic [10:0] sof_frame_index_out = 11'h0,
  output logic in_token_out = 1'b0
);
  // stale data is inverted so it never looks like the last packet
  task send_setup(input logic [63:0] d);
    @(posedge clk_in);
    setup_done_out <= 1'b1;
    setup_data_out <= d;
    @(posedge clk_in);
    setup_done_out <= 1'b0;
    setup_data_out <= ~d;
  endtask
  task send_sof(input logic [10:0] f, input logic e);
    @(posedge clk_in);
    sof_valid_out <= 1'b1;
    sof_error_out <= e;
    sof_frame_index_out <= f;
    @(posedge clk_in);
    sof_valid_out <= 1'b0;
    sof_error_out <= ~e;
    sof_frame_index_out <= ~f;
  endtask
  task send_status;
    @(posedge clk_in);
    status_done_out <= 1'b1;
    @(posedge clk_in);
    status_done_out <= 1'b0;
  endtask
  task send_in;
    @(posedge clk_in);
    in_token_out <= 1'b1;
    @(posedge clk_in);
    in_token_out <= 1'b0;
  endtask
endmodule // uep_host_model

// ==== sim/testbench.sv ====
// self-checking bench for the ep0 setup control block
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out, got;
  logic setup_done_in, status_done_in, sof_valid_in, sof_error_in, in_token_in;
  logic [63:0] setup_data_in;
  logic [10:0] sof_frame_index_in;
  logic [6:0] device_address_out;
  logic ep0_in_nak_out, ep0_in_stall_out, ep0_out_nak_out, ep0_out_stall_out;
  logic ep0_in_toggle_out, ep0_out_toggle_out, ep0_in_force_nak_resp_out, irq_out;
  logic [3:0] ep0_packet_limit_out;
  int failures = 0;
  int samples_checked = 0;
  // rows: write flag, address, write data, expected read
  logic [24:0] rows [9] = '{
    {1'b0, 8'hee, 8'h00, 8'h80},
    {1'b0, 8'hef, 8'h00, 8'h00},
    {1'b0, 8'hf0, 8'h00, 8'h40},
    {1'b0, 8'he8, 8'h00, 8'h00},
    {1'b0, 8'hea, 8'h00, 8'h00},
    {1'b1, 8'hf0, 8'hff, 8'h78},
    {1'b1, 8'he8, 8'h2a, 8'h2a},
    {1'b1, 8'hee, 8'h55, 8'h80},
    {1'b1, 8'h10, 8'h5a, 8'h00}};
  always #20 clk_in = ~clk_in;
  uep_ep0_setup_ctrl u_uep_ep0_setup_ctrl (.*);
  uep_host_model u_uep_host_model (.clk_in(clk_in), .setup_done_out(setup_done_in),
    .setup_data_out(setup_data_in), .status_done_out(status_done_in), .sof_valid_out(sof_valid_in),
    .sof_error_out(sof_error_in), .sof_frame_index_out(sof_frame_index_in), .in_token_out(in_token_in));
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
      begin
        failures++;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    got = reg_rdata_out;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask
  // irq is registered, so let the mask or clear land first
  task irq_chk(input logic e);
    repeat (2) @(posedge clk_in);
    #1;
    chk({7'h00, irq_out}, {7'h00, e});
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    report_and_stop;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][24])
        wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    chk({4'h0, ep0_packet_limit_out}, 8'h0f);
    $display("register rows done");
    u_uep_host_model.send_setup({8'h12, 32'h0, 8'h33, 8'h05, 8'h00});
    wr(8'hf2, 8'h00);
    rdc(8'hf2, 8'h12);
    rdc(8'hf3, 8'h12);
    rdc(8'he7, 8'h12);
    rdc(8'hea, 8'h01);
    u_uep_host_model.send_in;
    #1;
    chk({7'h00, ep0_in_force_nak_resp_out}, 8'h01);
    u_uep_host_model.send_status;
    rdc(8'he8, 8'h33);
    rdc(8'hf8, 8'h03);
    wr(8'hf9, 8'h00);
    irq_chk(1'b0);
    wr(8'hf9, 8'h01);
    irq_chk(1'b1);
    wr(8'hf8, 8'hff);
    irq_chk(1'b0);
    rdc(8'hf8, 8'h00);
    $display("auto address done");
    wr(8'hea, 8'h00);
    wr(8'hf2, 8'h01);
    rdc(8'hf2, 8'h11);
    wr(8'hf2, 8'h05);
    rdc(8'hf2, 8'h01);
    u_uep_host_model.send_setup(64'h0);
    rdc(8'hf2, 8'h12);
    wr(8'hfa, 8'h00);
    wr(8'he8, 8'h80);
    u_uep_host_model.send_setup({8'h00, 32'h0, 8'h45, 8'h05, 8'h00});
    u_uep_host_model.send_status;
    rd(8'he8);
    chk(got & 8'h7f, 8'h45);
    chk({1'b0, device_address_out}, 8'h45);
    wr(8'he8, 8'h10);
    u_uep_host_model.send_setup({8'h00, 32'h0, 8'h22, 8'h05, 8'h00});
    u_uep_host_model.send_status;
    rdc(8'he8, 8'h10);
    $display("lock and arm done");
    u_uep_host_model.send_sof(11'h5a3, 1'b0);
    rdc(8'hee, 8'h05);
    u_uep_host_model.send_sof(11'h123, 1'b0);
    rdc(8'hef, 8'ha3);
    u_uep_host_model.send_sof(11'h7ff, 1'b1);
    rdc(8'hee, 8'h81);
    rdc(8'hef, 8'h23);
    $display("frame number done");
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rdc(8'hee, 8'h80);
    rdc(8'hf0, 8'h40);
    chk({4'h0, ep0_packet_limit_out}, 8'h08);
    rdc(8'hf2, 8'h00);
    $display("second reset done");
    report_and_stop;
  end
endmodule // testbench
